// [dv/hbs_relay_model.sv]
// Relay model standing between brake release output and brake coil.
// Assumes coil drive on clk; contact closes a few cycles after pickup.
`timescale 1ns/1ps

module hbs_relay_model #(
    parameter int PICKUP = 3
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic coil,
    output logic      contact
);
    logic [PICKUP-1:0] lag;    // Armature travel time

    // Contact follows coil late; brake power sits on the user side
    always_ff @(posedge clk) begin
        lag     <= rst ? '0 : {lag[PICKUP-2:0], coil};
        contact <= rst ? 1'b0 : lag[PICKUP-1];
    end
endmodule

// [dv/hbs_top_chk.sv]
// Port checker for the holding brake sequencer.
// Assumes it is bound onto hbs_top; one clock, sync reset.
`timescale 1ns/1ps
`include "hbs_regs.svh"

module hbs_top_chk
    import hbs_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       servo_enable_in,
    input wire hbs_speed_t speed_abs,
    input wire logic       cfg_load,
    input wire hbs_speed_t cfg_standstill_speed_threshold,
    input wire hbs_time_t  cfg_standstill_brake_delay,
    input wire hbs_time_t  cfg_motion_brake_wait_time,
    input wire hbs_speed_t cfg_motion_brake_action_speed,
    input wire logic       excite_out,
    input wire logic       brake_release_out,
    input wire logic       stop_moving,
    input wire hbs_speed_t standstill_speed_threshold,
    input wire hbs_time_t  standstill_brake_delay,
    input wire hbs_time_t  motion_brake_wait_time,
    input wire hbs_speed_t motion_brake_action_speed
);
    int cnt;    // Cycles spent coasting

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Clamp helper, settings saturate rather than reject
    function automatic hbs_speed_t lim(input hbs_speed_t v, input hbs_speed_t m);
        return (v > m) ? m : v;
    endfunction

    // Same clamp for the millisecond settings, kept at their own width
    function automatic hbs_time_t lim_t(input hbs_time_t v, input hbs_time_t m);
        return (v > m) ? m : v;
    endfunction

    // Coast length counter
    always_ff @(posedge clk) begin
        cnt <= (rst || !stop_moving) ? 0 : cnt + 1;
    end

    a_reset_clear: assert property (disable iff (1'b0) rst |=>
        !excite_out && !brake_release_out && !stop_moving) else $error("reset outputs");
    a_reset_default: assert property (disable iff (1'b0) rst |=>
        standstill_speed_threshold == `HBS_THRESH_DEF && standstill_brake_delay ==
        `HBS_SB_DELAY_DEF && motion_brake_wait_time == `HBS_MB_WAIT_DEF &&
        motion_brake_action_speed == `HBS_MB_SPEED_DEF) else $error("defaults");
    a_load_thresh: assert property (cfg_load |=> standstill_speed_threshold ==
        lim($past(cfg_standstill_speed_threshold), `HBS_THRESH_MAX)) else $error("thresh");
    a_load_delay: assert property (cfg_load |=> standstill_brake_delay ==
        lim_t($past(cfg_standstill_brake_delay), `HBS_SB_DELAY_MAX)) else $error("delay");
    a_load_wait: assert property (cfg_load |=> motion_brake_wait_time ==
        lim_t($past(cfg_motion_brake_wait_time), `HBS_MB_WAIT_MAX)) else $error("wait");
    a_load_speed: assert property (cfg_load |=> motion_brake_action_speed ==
        lim($past(cfg_motion_brake_action_speed), `HBS_MB_SPEED_MAX)) else $error("speed");
    a_enable_release: assert property (servo_enable_in [*4] |=>
        excite_out && brake_release_out) else $error("no release when enabled");
    a_coast_dark: assert property (stop_moving |-> !excite_out)
        else $error("excited while coasting");
    a_hold_excited: assert property (brake_release_out && !stop_moving |-> excite_out)
        else $error("released without excitation");
    a_path_moving: assert property ($rose(stop_moving) |->
        $past(speed_abs) > $past(standstill_speed_threshold)) else $error("wrong path");
    // Pin held low long enough that an enable return cannot abort the stop first
    a_speed_end: assert property (!servo_enable_in [*4] ##0
        (stop_moving && speed_abs <= motion_brake_action_speed)
        |-> ##[1:2] !brake_release_out) else $error("brake late on speed");
    a_wait_bound: assert property (stop_moving |->
        cnt <= (motion_brake_wait_time + 1) * TICK_CYCLES + 4) else $error("coast too long");

    c_coast: cover property ($rose(stop_moving));
    c_hold_end: cover property ($fell(excite_out) && !$past(stop_moving));
    c_load: cover property (cfg_load);
endmodule

// [dv/hbs_top_tb_top.sv]
// Testbench for the holding brake sequencer with relay model.
// Assumes a 10-cycle tick so a millisecond is ten clocks.
`timescale 1ns/1ps

module hbs_top_tb_top;
    import hbs_pkg::*;
    localparam int TK = 10;    // Shortened tick period
    logic       clk = 1'b0, rst = 1'b1, en = 1'b0, ld = 1'b0, ex, br, sm, ct;
    hbs_speed_t spd = '0, ct_thr = '0, ct_act = '0, thr, act;
    hbs_time_t  ct_dly = '0, ct_wt = '0, dly, wt;
    int         n_errors = 0, n_tests = 0, n;

    always #5 clk = ~clk;

    hbs_top #(.TICK_CYCLES(TK)) u_hbs_top (.clk(clk), .rst(rst), .servo_enable_in(en),
        .speed_abs(spd), .cfg_load(ld), .cfg_standstill_speed_threshold(ct_thr),
        .cfg_standstill_brake_delay(ct_dly), .cfg_motion_brake_wait_time(ct_wt),
        .cfg_motion_brake_action_speed(ct_act), .excite_out(ex), .brake_release_out(br),
        .stop_moving(sm), .standstill_speed_threshold(thr), .standstill_brake_delay(dly),
        .motion_brake_wait_time(wt), .motion_brake_action_speed(act));
    hbs_relay_model u_hbs_relay_model (.clk(clk), .rst(rst), .coil(br), .contact(ct));

    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rng(input int lo, input int hi);
        chk(12'(n >= lo && n <= hi), 12'h001);
    endtask
    task cfg(input hbs_speed_t t, input hbs_time_t d, input hbs_time_t w, input hbs_speed_t a);
        {ct_thr, ct_dly, ct_wt, ct_act} = {t, d, w, a};
        ld = 1'b1;
        step(1);
        ld = 1'b0;
    endtask
    // Bounded wait for excitation or release to go away
    task wait_low(input logic sel);
        while (((sel ? br : ex) !== 1'b0) && n < 200) begin
            step(1);
            n++;
        end
    endtask
    task fall(input logic sel);
        en = 1'b0;
        n = 0;
        wait_low(sel);
    endtask
    task enable;
        en = 1'b1;
        step(6);
        chk({ex, br}, 12'h003);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        step(5);
        rst = 1'b0;
        chk({ex, br, sm}, 12'h000);
        chk(thr, 12'h005); chk(dly, 12'h000); chk(wt, 12'h1f4); chk(act, 12'h064);
        cfg(12'hfff, 11'h7ff, 11'h7ff, 12'hfff);
        chk(thr, 12'h3e8); chk(dly, 12'h7d0); chk(wt, 12'h7d0); chk(act, 12'hbb8);
        cfg(12'h032, 11'h003, 11'h004, 12'h064);
        spd = 12'h00a;
        enable();
        fall(1'b0); rng(30, 38);
        step(5); chk({br, ct}, 12'h000);
        spd = 12'h032;
        enable();
        en = 1'b0; step(8); chk({ex, sm}, 12'h002);
        cfg(12'h032, 11'h000, 11'h004, 12'h064);
        enable();
        fall(1'b0); rng(4, 7);
        spd = 12'h1f4;
        enable();
        fall(1'b0); rng(3, 5);
        chk(br, 12'h001);
        chk(sm, 12'h001);
        wait_low(1'b1); rng(40, 48);
        enable();
        en = 1'b0; n = 10; step(10); spd = 12'h032;
        wait_low(1'b1); rng(11, 14);
        spd = 12'h1f4;
        enable();
        en = 1'b0; step(10); en = 1'b1; step(40);
        chk({ex, br, sm}, 12'h006);
        report_and_stop();
    end
endmodule

bind hbs_top hbs_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst(rst),
    .servo_enable_in(servo_enable_in), .speed_abs(speed_abs), .cfg_load(cfg_load),
    .cfg_standstill_speed_threshold(cfg_standstill_speed_threshold),
    .cfg_standstill_brake_delay(cfg_standstill_brake_delay),
    .cfg_motion_brake_wait_time(cfg_motion_brake_wait_time),
    .cfg_motion_brake_action_speed(cfg_motion_brake_action_speed),
    .excite_out(excite_out), .brake_release_out(brake_release_out),
    .stop_moving(stop_moving), .standstill_speed_threshold(standstill_speed_threshold),
    .standstill_brake_delay(standstill_brake_delay),
    .motion_brake_wait_time(motion_brake_wait_time),
    .motion_brake_action_speed(motion_brake_action_speed));

// [inc/hbs_pkg.sv]
// Types shared by the holding brake sequencer files.
// Assumes hbs_regs.svh is on the include path.
`include "hbs_regs.svh"

package hbs_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        HBS_IDLE    = 3'b000,
        HBS_RUN     = 3'b001,
        HBS_HOLD    = 3'b010,
        HBS_COAST   = 3'b011
    } hbs_state_e;

    typedef logic [`HBS_SPEED_W-1:0] hbs_speed_t;
    typedef logic [`HBS_TIME_W-1:0]  hbs_time_t;

endpackage

// [inc/hbs_regs.svh]
// Constants for the holding brake sequencer: setting limits, defaults, tick timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH

`define HBS_CLK_HZ            100000000
`define HBS_TICK_MS           1
`define HBS_TICK_CYCLES       (`HBS_CLK_HZ / 1000 * `HBS_TICK_MS)
`define HBS_SPEED_W           12
`define HBS_TIME_W            11
`define HBS_THRESH_MAX        12'h3e8
`define HBS_THRESH_DEF        12'h005
`define HBS_SB_DELAY_MAX      11'h7d0
`define HBS_SB_DELAY_DEF      11'h000
`define HBS_MB_WAIT_MAX       11'h7d0
`define HBS_MB_WAIT_DEF       11'h1f4
`define HBS_MB_SPEED_MAX      12'hbb8
`define HBS_MB_SPEED_DEF      12'h064
`define HBS_TIME_ZERO         11'h000
`define HBS_TIME_ONE          11'h001

`endif

// [inc/hbs_tick_if.sv]
// Carrier between the top sequencer and its millisecond tick divider.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps

interface hbs_tick_if;
    logic clear;    // Restart the divider phase
    logic tick;     // One-cycle pulse each millisecond

    modport src (input clear, output tick);
    modport dst (output clear, input tick);
endinterface

// [logic/hbs_tick_gen.sv]
// Millisecond tick divider for the holding brake sequencer.
// Assumes a free-running clk at the rate given in hbs_regs.svh.
`timescale 1ns/1ps
`include "hbs_regs.svh"

module hbs_tick_gen
    import hbs_pkg::*;
#(
    parameter int TICK_CYCLES = `HBS_TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    hbs_tick_if.src   tk
);

    // ****************************************************************
    // Divider
    // ****************************************************************
    logic [31:0] count;    // Cycles since last tick

    // Restart on clear so the first ms of a sequence is a full one
    always_ff @(posedge clk) begin
        if (rst || tk.clear) begin
            count   <= 32'h0;
            tk.tick <= 1'b0;
        end else if (count == 32'(TICK_CYCLES - 1)) begin
            count   <= 32'h0;
            tk.tick <= 1'b1;
        end else begin
            count   <= count + 32'h1;
            tk.tick <= 1'b0;
        end
    end

endmodule

// [logic/hbs_top.sv]
// Holding brake sequencer: servo-off excitation and brake release timing.
// Assumes speed and settings come from logic on clk; enable comes from a pin.
`timescale 1ns/1ps
`include "hbs_regs.svh"

module hbs_top
    import hbs_pkg::*;
#(
    parameter int TICK_CYCLES = `HBS_TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       servo_enable_in,
    input  wire hbs_speed_t speed_abs,
    input  wire logic       cfg_load,
    input  wire hbs_speed_t cfg_standstill_speed_threshold,
    input  wire hbs_time_t  cfg_standstill_brake_delay,
    input  wire hbs_time_t  cfg_motion_brake_wait_time,
    input  wire hbs_speed_t cfg_motion_brake_action_speed,
    output logic            excite_out,
    output logic            brake_release_out,
    output logic            stop_moving,
    output hbs_speed_t      standstill_speed_threshold,
    output hbs_time_t       standstill_brake_delay,
    output hbs_time_t       motion_brake_wait_time,
    output hbs_speed_t      motion_brake_action_speed
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Clamp a speed setting to its documented top
    function automatic hbs_speed_t clamp_speed(input hbs_speed_t v, input hbs_speed_t lim);
        clamp_speed = (v > lim) ? lim : v;
    endfunction

    // Clamp a time setting to its documented top
    function automatic hbs_time_t clamp_time(input hbs_time_t v, input hbs_time_t lim);
        clamp_time = (v > lim) ? lim : v;
    endfunction

    // ****************************************************************
    // Settings
    // ****************************************************************

    // Out-of-range writes are clamped, not rejected, so the value is always usable
    always_ff @(posedge clk) begin
        if (rst) begin
            standstill_speed_threshold <= `HBS_THRESH_DEF;
            standstill_brake_delay     <= `HBS_SB_DELAY_DEF;
            motion_brake_wait_time     <= `HBS_MB_WAIT_DEF;
            motion_brake_action_speed  <= `HBS_MB_SPEED_DEF;
        end else if (cfg_load) begin
            standstill_speed_threshold <= clamp_speed(cfg_standstill_speed_threshold,
                                                      `HBS_THRESH_MAX);
            standstill_brake_delay     <= clamp_time(cfg_standstill_brake_delay,
                                                     `HBS_SB_DELAY_MAX);
            motion_brake_wait_time     <= clamp_time(cfg_motion_brake_wait_time,
                                                     `HBS_MB_WAIT_MAX);
            motion_brake_action_speed  <= clamp_speed(cfg_motion_brake_action_speed,
                                                      `HBS_MB_SPEED_MAX);
        end
    end

    // ****************************************************************
    // Enable synchroniser
    // ****************************************************************
    logic en_meta;    // First stage, read only by en_sync
    logic en_sync;    // Second stage
    logic en_prev;    // Delayed copy for edge detect

    // Enable is a pin; two flops before any logic sees it
    always_ff @(posedge clk) begin
        if (rst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
            en_prev <= 1'b0;
        end else begin
            en_meta <= servo_enable_in;
            en_sync <= en_meta;
            en_prev <= en_sync;
        end
    end

    logic en_fall;    // Enable just went off
    assign en_fall = en_prev && !en_sync;

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    hbs_tick_if tk ();

    assign tk.clear = en_fall;

    hbs_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk (clk),
        .rst (rst),
        .tk  (tk)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    hbs_state_e state;       // Current state
    hbs_time_t  remain;      // Milliseconds left in the delay
    logic       moving;      // Speed above threshold at the fall

    assign moving = speed_abs > standstill_speed_threshold;

    logic timer_done;        // Delay exhausted, counting the current tick
    assign timer_done = (remain == `HBS_TIME_ZERO) ||
                        (tk.tick && remain == `HBS_TIME_ONE);

    // State and delay counter
    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= HBS_IDLE;
            remain <= `HBS_TIME_ZERO;
        end else begin
            case (state)
                HBS_IDLE: begin
                    // Idle: wait for enable
                    if (en_sync) begin
                        state <= HBS_RUN;
                    end
                end
                HBS_RUN: begin
                    if (en_fall) begin
                        if (moving) begin
                            state  <= HBS_COAST;
                            remain <= motion_brake_wait_time;
                        end else begin
                            state  <= HBS_HOLD;
                            remain <= standstill_brake_delay;
                        end
                    end
                end
                HBS_HOLD: begin
                    // Enable back mid-sequence aborts and clears the delay
                    if (en_sync) begin
                        state  <= HBS_RUN;
                        remain <= `HBS_TIME_ZERO;
                    end else if (timer_done) begin
                        state  <= HBS_IDLE;
                        remain <= `HBS_TIME_ZERO;
                    end else if (tk.tick) begin
                        remain <= remain - `HBS_TIME_ONE;
                    end
                end
                HBS_COAST: begin
                    if (en_sync) begin
                        state  <= HBS_RUN;
                        remain <= `HBS_TIME_ZERO;
                    end else if (timer_done ||
                                 speed_abs <= motion_brake_action_speed) begin
                        state  <= HBS_IDLE;
                        remain <= `HBS_TIME_ZERO;
                    end else if (tk.tick) begin
                        remain <= remain - `HBS_TIME_ONE;
                    end
                end
                default: begin
                    state  <= HBS_IDLE;
                    remain <= `HBS_TIME_ZERO;
                end
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    hbs_state_e next_state_out;    // State the outputs will follow
    always_comb begin
        next_state_out = state;
        if (state == HBS_RUN && en_fall) begin
            next_state_out = moving ? HBS_COAST : HBS_HOLD;
        end
    end

    // Registered outputs; brake release drops only when the sequence ends
    always_ff @(posedge clk) begin
        if (rst) begin
            excite_out        <= 1'b0;
            brake_release_out <= 1'b0;
            stop_moving       <= 1'b0;
        end else begin
            // Excitation kept through the standstill hold, cut at once when moving
            excite_out        <= (state == HBS_RUN && !(en_fall && moving)) ||
                                 (state == HBS_HOLD);
            // Relay coil on keeps the brake released
            brake_release_out <= (state == HBS_RUN) || (state == HBS_HOLD) ||
                                 (state == HBS_COAST);
            stop_moving       <= (next_state_out == HBS_COAST);
        end
    end

endmodule
